// File: design/serial_link_status.sv
// Serial port link status, restart, error record and settings-change control
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "serial_link_status_map.svh"
module serial_link_status
  import serial_link_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port events from the serial engine
  input wire logic [7:0] unit_comm_i,
  input wire logic parity_err_i,
  input wire logic framing_err_i,
  input wire logic overrun_err_i,
  input wire logic timeout_err_i,
  // Port control toward the serial engine
  output logic port_reinit_o,
  output logic port_retry_o,
  output logic settings_apply_o,
  // Interrupt
  output logic irq_o
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] active_q; // Link-active flags
  logic restart_q; // Restart request bit
  logic [7:0] err_q; // Sticky error record
  logic busy_q; // Settings change busy
  logic [1:0] mode_q; // Link mode field
  logic polling_q; // Polling side select
  logic [2:0] irq_st_q; // Interrupt status
  logic [2:0] irq_en_q; // Interrupt enable
  logic ack_q; // Bus acknowledge
  logic [31:0] rdat_q; // Read data
  logic [7:0] err_raw; // Raw fault vector
  logic [7:0] err_mask; // Mode-dependent enable
  logic [7:0] err_new; // Masked new faults
  logic wr_stb; // Write strobe
  logic rd_stb; // Read strobe
  logic restart_done; // Restart finished pulse
  logic settings_done; // Settings finished pulse
  logic retry_done; // Retry interval expired
  logic [7:0] retry_cnt_q; // Retry interval counter
  logic retry_pend_q; // Retry owed after fault
  restart_state_t rs_q; // Restart sequencer
  countdown_if tmr_rs(); // Restart timer
  countdown_if tmr_st(); // Settings timer

  // ----------------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------------
  // Writes land at the edge where the master samples ack high
  // Read data is registered one edge earlier so it stands at that edge
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
  assign rd_stb = wb_cyc_i && wb_stb_i && !ack_q;

  // Acknowledge one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
  end

  // Read multiplexer, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_q <= 32'h0000_0000;
    else if (rd_stb)
    begin
      case (wb_adr_i)
        `REG_LINK_ACTIVE: rdat_q <= {24'h000000, active_q};
        `REG_RESTART: rdat_q <= {31'h00000000, restart_q};
        `REG_ERRORS: rdat_q <= {24'h000000, err_q};
        `REG_BUSY: rdat_q <= {31'h00000000, busy_q};
        `REG_CONTROL: rdat_q <= {29'h00000000, polling_q, mode_q};
        `REG_IRQ_STATUS: rdat_q <= {29'h00000000, irq_st_q};
        `REG_IRQ_ENABLE: rdat_q <= {29'h00000000, irq_en_q};
        default: rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Mode and side select
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= 2'h0;
      polling_q <= 1'b0;
    end
    else if (wr_stb && wb_adr_i == `REG_CONTROL)
    begin
      mode_q <= wb_dat_i[1:0];
      polling_q <= wb_dat_i[`CTL_POLLING];
    end
  end

  // ----------------------------------------------------------------
  // Link-active flags
  // ----------------------------------------------------------------
  // Follow engine per unit in either link mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      active_q <= `RST_BYTE;
    else if (rs_q != RS_IDLE)
      active_q <= `RST_BYTE;
    else if (mode_q == 2'(MODE_TERMINAL) || mode_q == 2'(MODE_CONTROLLER))
      active_q <= unit_comm_i;
    else
      active_q <= `RST_BYTE;
  end

  // ----------------------------------------------------------------
  // Restart sequencer
  // ----------------------------------------------------------------
  assign tmr_rs.load = (rs_q == RS_IDLE) && restart_q;
  assign tmr_rs.count = 8'(`RESTART_CYCLES);

  // Request, flush, release
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rs_q <= RS_IDLE;
    else
    begin
      case (rs_q)
        RS_IDLE: if (restart_q) rs_q <= RS_FLUSH;
        RS_FLUSH: if (tmr_rs.done) rs_q <= RS_DONE;
        RS_DONE: rs_q <= RS_IDLE;
        default: rs_q <= RS_IDLE;
      endcase
    end
  end

  assign restart_done = (rs_q == RS_DONE);
  // Hold engine in reinit: frames dropped, rx/tx idle
  assign port_reinit_o = (rs_q == RS_FLUSH);

  // Restart bit: software sets, hardware clears
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      restart_q <= 1'b0;
    else if (wr_stb && wb_adr_i == `REG_RESTART && wb_dat_i[0])
      restart_q <= 1'b1;
    else if (restart_done)
      restart_q <= 1'b0;
  end

  countdown_timer u_rs_timer
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tmr(tmr_rs.timer)
  );

  // ----------------------------------------------------------------
  // Error record
  // ----------------------------------------------------------------
  // Raw fault vector in documented bit order
  always_comb
  begin
    err_raw = 8'h00;
    err_raw[`ERR_PARITY] = parity_err_i;
    err_raw[`ERR_FRAMING] = framing_err_i;
    err_raw[`ERR_OVERRUN] = overrun_err_i;
    err_raw[`ERR_TIMEOUT] = timeout_err_i;
  end

  // Which bits each mode may report
  always_comb
  begin
    case (mode_q)
      2'(MODE_TERMINAL): err_mask = `ERR_MASK_TERMINAL;
      2'(MODE_CONTROLLER): err_mask = polling_q ? `ERR_MASK_POLLING : `ERR_MASK_POLLED;
      default: err_mask = 8'h3C;
    endcase
  end

  assign err_new = err_raw & err_mask;

  // Sticky until restart; new fault wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      err_q <= `RST_BYTE;
    else if (restart_done)
      err_q <= err_new;
    else
      err_q <= err_q | err_new;
  end

  // ----------------------------------------------------------------
  // Polling-side retry
  // ----------------------------------------------------------------
  assign retry_done = retry_pend_q && (retry_cnt_q == 8'h00);

  // Retry RETRY_CYCLES after the last fault, no restart needed
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      retry_pend_q <= 1'b0;
      retry_cnt_q <= 8'h00;
    end
    else if (mode_q == 2'(MODE_CONTROLLER) && polling_q && err_raw != 8'h00)
    begin
      retry_pend_q <= 1'b1;
      retry_cnt_q <= 8'(`RETRY_CYCLES - 1);
    end
    else if (retry_done)
      retry_pend_q <= 1'b0;
    else if (retry_pend_q)
      retry_cnt_q <= retry_cnt_q - 8'h01;
  end

  assign port_retry_o = retry_done;

  // ----------------------------------------------------------------
  // Settings change
  // ----------------------------------------------------------------
  assign tmr_st.load = wr_stb && wb_adr_i == `REG_CONTROL && wb_dat_i[`CTL_UPDATE] && !busy_q;
  assign tmr_st.count = 8'(`SETTINGS_CYCLES);
  assign settings_done = tmr_st.done;
  assign settings_apply_o = settings_done;

  // Busy from update instruction until applied
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      busy_q <= 1'b0;
    else if (tmr_st.load)
      busy_q <= 1'b1;
    else if (settings_done)
      busy_q <= 1'b0;
  end

  countdown_timer u_st_timer
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tmr(tmr_st.timer)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Sticky events, set beats clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_st_q <= 3'h0;
    else
    begin
      irq_st_q <= (irq_st_q & ~((wr_stb && wb_adr_i == `REG_IRQ_CLEAR) ? wb_dat_i[2:0] : 3'h0))
        | {settings_done, restart_done, (err_new != 8'h00)};
    end
  end

  // Enable register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_en_q <= 3'h0;
    else if (wr_stb && wb_adr_i == `REG_IRQ_ENABLE)
      irq_en_q <= wb_dat_i[2:0];
  end

  assign irq_o = |(irq_st_q & irq_en_q);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_restart_req;
    rs_q == RS_IDLE && restart_q;
  endsequence

  sequence s_restart_end;
    rs_q == RS_DONE;
  endsequence

  a_restart_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    s_restart_req |-> ##[1:12] s_restart_end ##1 !restart_q)
    else $error("restart bit not cleared");

  a_restart_starts: assert property (@(posedge clk_i) disable iff (rst_i)
    s_restart_req |=> port_reinit_o)
    else $error("restart did not reinit port");

  a_reinit_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    port_reinit_o |=> active_q == 8'h00)
    else $error("link flags during reinit");

  a_err_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    !restart_done |=> (err_q & $past(err_q)) == $past(err_q))
    else $error("error flag lost without restart");

  a_terminal_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_q == 2'(MODE_TERMINAL) && !restart_done |=> (err_q & ~$past(err_q) & 8'hDF) == 8'h00)
    else $error("non-timeout error in terminal mode");

  a_polled_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_q == 2'(MODE_CONTROLLER) && !polling_q && framing_err_i |=> err_q[`ERR_FRAMING])
    else $error("polled framing error not recorded");

  a_poll_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_q == 2'(MODE_CONTROLLER) && polling_q && !restart_done |=> (err_q & ~$past(err_q) & 8'hDF) == 8'h00)
    else $error("polling side reported non-timeout");

  a_retry_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_q == 2'(MODE_CONTROLLER) && polling_q && timeout_err_i |-> ##[1:40] port_retry_o)
    else $error("no retry after fault");

  a_busy_window: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr_st.load |=> busy_q [*3] ##[1:20] !busy_q)
    else $error("settings busy flag wrong");

  a_active_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_q == 2'(MODE_TERMINAL) && rs_q == RS_IDLE && $stable(mode_q) |=> active_q == $past(unit_comm_i))
    else $error("link flags not following unit");
endmodule
`default_nettype wire

// File: design/serial_link_status_map.svh
// Register map, field positions and timing counts of the serial link status block
//
// Contract
// - Eight link-active flags, units zero to seven
// - Flags also set in controller link slaves
// - All flags and bits clear at reset
// - Writing one to restart bit reinitialises port
// - Restart bit self-clears after restart completes
// - Error bits: parity2 framing3 overrun4 timeout5
// - Detected port faults recorded in error field
// - Terminal link mode records only timeout
// - Polling side records only timeout
// - Polled side records timeout overrun framing
// - Polling side retries after error automatically
// - Traffic resumes once error cause is gone
// - Error flags held until port restart
// - Busy flag set on settings update until applied
`ifndef SERIAL_LINK_STATUS_MAP_SVH
`define SERIAL_LINK_STATUS_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_LINK_ACTIVE 8'h00
`define REG_RESTART 8'h04
`define REG_ERRORS 8'h08
`define REG_BUSY 8'h0C
`define REG_CONTROL 8'h10
`define REG_IRQ_STATUS 8'h14
`define REG_IRQ_ENABLE 8'h18
`define REG_IRQ_CLEAR 8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ERR_PARITY 2
`define ERR_FRAMING 3
`define ERR_OVERRUN 4
`define ERR_TIMEOUT 5
`define CTL_MODE_LO 0
`define CTL_POLLING 2
`define CTL_UPDATE 3
`define IRQ_ERROR 0
`define IRQ_RESTART_DONE 1
`define IRQ_SETTINGS_DONE 2

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define ERR_MASK_TERMINAL 8'h20
`define ERR_MASK_POLLING 8'h20
`define ERR_MASK_POLLED 8'h38

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define RESTART_CYCLES 8
`define SETTINGS_CYCLES 16
`define RETRY_CYCLES 32

`endif

// File: design/serial_link_pkg.sv
// Types shared by the serial link status block
package serial_link_pkg;
  // Link mode of the port
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_TERMINAL,
    MODE_CONTROLLER
  } link_mode_t;
  // Restart sequencer states
  typedef enum logic [1:0] {
    RS_IDLE,
    RS_FLUSH,
    RS_DONE
  } restart_state_t;
endpackage

// File: design/countdown_if.sv
// Interface between the status block and its countdown timer
`timescale 1ns/1ps
`default_nettype none
interface countdown_if;
  logic load; // Start the count
  logic [7:0] count; // Cycles to count
  logic done; // One-cycle pulse at expiry
  logic busy; // Counting
  modport owner (output load, output count, input done, input busy);
  modport timer (input load, input count, output done, output busy);
endinterface
`default_nettype wire

// File: design/countdown_timer.sv
// Loadable down-counter with expiry pulse
`timescale 1ns/1ps
`default_nettype none
module countdown_timer
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  countdown_if.timer tmr
);
  logic [7:0] cnt_q; // Remaining cycles
  logic run_q; // Counting flag
  logic done_q; // Expiry pulse

  // Count down while running
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (tmr.load)
    begin
      cnt_q <= tmr.count;
      run_q <= 1'b1;
      done_q <= 1'b0;
    end
    else if (run_q && cnt_q <= 8'h01)
    begin
      run_q <= 1'b0;
      done_q <= 1'b1;
    end
    else
    begin
      cnt_q <= run_q ? cnt_q - 8'h01 : cnt_q;
      done_q <= 1'b0;
    end
  end

  assign tmr.done = done_q;
  assign tmr.busy = run_q;
endmodule
`default_nettype wire

// File: test/serial_engine_model.sv
// Behavioural serial engine on the far side of the status block
`timescale 1ns/1ps
`default_nettype none
module serial_engine_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Scenario commands
  input wire logic [7:0] units_i,
  input wire logic [3:0] fault_i,
  // Control from the status block
  input wire logic port_reinit_i,
  // Events toward the status block
  output logic [7:0] unit_comm_o,
  output logic parity_err_o,
  output logic framing_err_o,
  output logic overrun_err_o,
  output logic timeout_err_o
);
  // Units drop out while the port restarts
  always_ff @(posedge clk_i)
  begin
    if (rst_i || port_reinit_i)
      unit_comm_o <= 8'h00;
    else
      unit_comm_o <= units_i;
  end

  // Fault pulses, one cycle per command
  always_ff @(posedge clk_i)
  begin
    {timeout_err_o, overrun_err_o, framing_err_o, parity_err_o} <= rst_i ? 4'h0 : fault_i;
  end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the serial link status block
`timescale 1ns/1ps
`default_nettype none
`include "serial_link_status_map.svh"
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] unit_comm, units = 8'h00;
  logic [3:0] fault = 4'h0;
  logic par, frm, ovr, tmo, reinit, retry, apply, irq_o;
  int fail_count = 0;
  int checks_done = 0;

  // Clock, 100 ns period
  always #50 clk_i = ~clk_i;

  serial_link_status i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .unit_comm_i(unit_comm),
    .parity_err_i(par), .framing_err_i(frm), .overrun_err_i(ovr), .timeout_err_i(tmo),
    .port_reinit_o(reinit), .port_retry_o(retry), .settings_apply_o(apply), .irq_o(irq_o));

  serial_engine_model i_engine (.clk_i(clk_i), .rst_i(rst_i), .units_i(units),
    .fault_i(fault), .port_reinit_i(reinit), .unit_comm_o(unit_comm), .parity_err_o(par),
    .framing_err_o(frm), .overrun_err_o(ovr), .timeout_err_o(tmo));

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    fail_count++;
    $display("unexpected wait on %s: expected done seen none", what);
    conclude();
  endtask

  // Classic single Wishbone cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20)
      give_up("ack");
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] d;
    wb(1'b1, adr, wd, d);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, d);
    chk(what, exp, d);
  endtask

  // Poll a register until it shows a value
  task automatic poll(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    int n;
    n = 0;
    d = ~exp;
    while (d !== exp)
    begin
      wb(1'b0, adr, 32'h0, d);
      n++;
      if (n > 40)
        give_up("poll");
    end
  endtask

  task automatic inject(input logic [3:0] f);
    @(posedge clk_i);
    fault <= f;
    @(posedge clk_i);
    fault <= 4'h0;
    repeat (3) @(posedge clk_i);
  endtask

  // Restart request, self clear, error record wiped
  task automatic restart();
    wr(`REG_IRQ_CLEAR, 32'h7);
    wr(`REG_RESTART, 32'h1);
    rd_chk("restart bit", `REG_RESTART, 32'h1);
    chk("reinit", 32'h1, {31'h0, reinit});
    poll(`REG_RESTART, 32'h0);
    rd_chk("errors after restart", `REG_ERRORS, 32'h0);
    rd_chk("restart done irq", `REG_IRQ_STATUS, 32'h2);
  endtask

  task automatic s_reset();
    for (int a = 0; a < 8; a++)
      rd_chk("reset value", 8'(a * 4), 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
  endtask

  task automatic s_flags();
    units <= 8'hA5;
    wr(`REG_CONTROL, 32'h1);
    rd_chk("terminal flags", `REG_LINK_ACTIVE, 32'hA5);
    wr(`REG_CONTROL, 32'h2);
    wr(`REG_LINK_ACTIVE, 32'hFF);
    rd_chk("controller flags", `REG_LINK_ACTIVE, 32'hA5);
  endtask

  // Every mode sees all four faults; only its own bits stick
  task automatic s_errors();
    logic [7:0] ctl [4] = '{8'h00, 8'h01, 8'h06, 8'h02};
    logic [7:0] msk [4] = '{8'h3C, `ERR_MASK_TERMINAL, `ERR_MASK_POLLING, `ERR_MASK_POLLED};
    for (int i = 0; i < 4; i++)
    begin
      wr(`REG_CONTROL, {24'h0, ctl[i]});
      inject(4'hF);
      rd_chk("error field", `REG_ERRORS, {24'h0, msk[i]});
      restart();
    end
  endtask

  task automatic s_retry();
    int n;
    wr(`REG_CONTROL, 32'h6);
    inject(4'h8);
    n = 0;
    while (retry !== 1'b1 && n < 60)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 60)
      give_up("retry");
    rd_chk("flags after retry", `REG_LINK_ACTIVE, 32'hA5);
    rd_chk("error kept", `REG_ERRORS, 32'h20);
    restart();
  endtask

  task automatic s_settings();
    int n;
    wr(`REG_IRQ_CLEAR, 32'h7);
    wr(`REG_CONTROL, 32'hA);
    rd_chk("busy set", `REG_BUSY, 32'h1);
    n = 0;
    while (apply !== 1'b1 && n < 40)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 40)
      give_up("apply");
    rd_chk("busy clear", `REG_BUSY, 32'h0);
    rd_chk("settings done irq", `REG_IRQ_STATUS, 32'h4);
  endtask

  // Raise, mask and clear the interrupt
  task automatic s_irq();
    wr(`REG_IRQ_CLEAR, 32'h7);
    wr(`REG_IRQ_ENABLE, 32'h1);
    inject(4'h8);
    chk("irq raised", 32'h1, {31'h0, irq_o});
    wr(`REG_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    rd_chk("irq status", `REG_IRQ_STATUS, 32'h1);
    wr(`REG_IRQ_CLEAR, 32'h1);
    wr(`REG_IRQ_ENABLE, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
  endtask

  // Reset in mid-run wipes a raised error and interrupt
  task automatic s_rerst();
    inject(4'h8);
    chk("irq before reset", 32'h1, {31'h0, irq_o});
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("irq after reset", 32'h0, {31'h0, irq_o});
    s_reset();
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset();
    s_flags();
    s_errors();
    s_retry();
    s_settings();
    s_irq();
    s_rerst();
    conclude();
  end
endmodule
`default_nettype wire
